// *** scc_fpga_model.sv ***
/*
 * Behavioural configuration master: makes the serial clock in bursts
 * and gathers the bits seen on the data wire.
 * Assumes the bench resolves the data wire with its pull-up applied.
 */
`timescale 1ns/1ps
module scc_fpga_model (
   // Burst control from the bench
   input wire logic run,
   // Resolved data wire
   input wire logic data_wire,
   // Serial clock towards the memory
   output logic serial_config_clock,
   // Last sixteen bits, oldest in bit 0
   output logic [15:0] cap
);
   // Clock stands low between bursts, 15 ns period inside them
   initial
   begin
      serial_config_clock = 1'b0;
      forever
      begin
         wait (run);
         #7.5 serial_config_clock = 1'b1;
         #7.5 serial_config_clock = 1'b0;
      end
   end

   // Sample after the shifting edge so the new bit has settled
   initial
   begin
      cap = 16'h0000;
      forever
      begin
         @(posedge serial_config_clock);
         #0.5 cap = {data_wire, cap[15:1]};
      end
   end
endmodule

// *** scc_pkg.sv ***
/*
 * Shared constants, state codes and address-range helpers for the
 * serial configuration memory readout block.
 * Assumes a 250 MHz system clock and an address space of up to 19 bits.
 */
package scc_pkg;

   // Address and word geometry
   localparam int ADDR_W = 19;
   localparam int WORD_W = 16;
   localparam int BIT_W = 4;
   localparam logic [BIT_W-1:0] BIT_LAST = 4'hF;

   // Whole-device last address for each density
   localparam logic [ADDR_W-1:0] LAST_4M = 19'h3FFFF;
   localparam logic [ADDR_W-1:0] LAST_8M = 19'h7FFFF;

   // Partition size as a power of two (64K and 128K addresses)
   localparam int PART_SHIFT_4M = 16;
   localparam int PART_SHIFT_8M = 17;

   // Reset values
   localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
   localparam logic [BIT_W-1:0] BIT_RST = 4'h0;

   // Power-up hold time and its cycle count at the system rate
   localparam int SYS_CLK_PERIOD_NS = 4;
   localparam int PWRUP_TIME_NS = 1000;
   localparam int PWRUP_CYC = (PWRUP_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
   localparam int PWRUP_W = 12;

   // Cascade output sequencing
   typedef enum logic [2:0]
   {
      CH_IDLE = 3'h1,
      CH_LOW = 3'h2,
      CH_FOLLOW = 3'h4
   } scc_chain_e;

   // First address of the active range
   function automatic logic [ADDR_W-1:0] part_base(logic big, logic paged, logic [1:0] sel);
      logic [ADDR_W-1:0] wide;
      wide = {{(ADDR_W-2){1'b0}}, sel};
      if (!paged)
         part_base = ADDR_RST;
      else if (big)
         part_base = wide << PART_SHIFT_8M;
      else
         part_base = wide << PART_SHIFT_4M;
   endfunction

   // Last address of the active range
   function automatic logic [ADDR_W-1:0] part_last(logic big, logic paged, logic [1:0] sel);
      logic [ADDR_W-1:0] span;
      span = big ? (19'h00001 << PART_SHIFT_8M) : (19'h00001 << PART_SHIFT_4M);
      if (!paged)
         part_last = big ? LAST_8M : LAST_4M;
      else
         part_last = part_base(big, paged, sel) + span - 19'h00001;
   endfunction

endpackage

// *** scc_powerup.sv ***
/*
 * Power-up sequencer: holds busy high for a fixed count after reset.
 * Assumes reset is synchronous, active high, on the system clock.
 */
`timescale 1ns/1ps
module scc_powerup #(
   parameter int CYC = scc_pkg::PWRUP_CYC
) (
   // System clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // High until the sequence ends
   output logic busy_ff
);

   logic [scc_pkg::PWRUP_W-1:0] cnt_ff; // Elapsed cycles
   logic [scc_pkg::PWRUP_W-1:0] nxt_cnt;
   logic nxt_busy;

   // Count up while busy, then stop
   always_comb
   begin
      nxt_cnt = cnt_ff;
      nxt_busy = busy_ff;
      if (reset)
      begin
         nxt_cnt = '0;
         nxt_busy = 1'b1;
      end
      else if (busy_ff)
      begin
         nxt_cnt = cnt_ff + 12'h001;
         nxt_busy = (cnt_ff < scc_pkg::PWRUP_W'(CYC - 1));
      end
   end

   // Register
   always_ff @(posedge sys_clk)
   begin
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
   end

endmodule

// *** scc_readout.sv ***
/*
 * Readout side of a serial configuration memory: address and bit
 * counters on the serial clock, data pin drive, cascade output, paging,
 * power-up ready indication and the program-mode select.
 * Assumes the array answers mem_word for mem_addr within one serial clock
 * and that the configuring master supplies serial_config_clock.
 */
// Operation
// - Cascade output goes low at counter maximum
// - Paged: partition top is counter maximum
// - Two selects pick four 64K partitions
// - Larger part: four 128K partitions
// - Paging off: whole device one range
// - Cascade low while select low, enable high
// - Then track select; high after enable falls
// - Program mode: device pick acts as select
// - Ready held low during power-up
// - Program path low enters programming mode
// - Reset/enable low clears counter, floats data
// - Select high after reset freezes, floats
// - Enable high again starts counter, driver
// - Later reset pulse clears regardless of select
// - Float data after final bit
// - Counter cleared at power-up
// - Downstream drives data when select low
// - Counting and drive need select low, enable high
// - Select high stops counters, standby
// - Program mode ignores paging inputs
`timescale 1ns/1ps
module scc_readout #(
   parameter logic BIG_PART = 1'b0, // 1 selects the larger density
   parameter int PWRUP_CYC = scc_pkg::PWRUP_CYC
) (
   // System clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Serial clock from the configuring master
   input wire logic serial_config_clock,
   // Control pins
   input wire logic select_low,
   input wire logic reset_oe,
   input wire logic page_mode_on,
   input wire logic [1:0] partition_choice,
   input wire logic program_path_on,
   input wire logic program_device_pick,
   // Data pin
   input wire logic data_in,
   output logic data_out,
   output logic data_oe_n,
   // Cascade output
   output logic chain_out_low,
   // Open-collector ready pin
   output logic ready_out,
   output logic ready_oe_n,
   // Array read port, serial clock domain
   output logic [scc_pkg::ADDR_W-1:0] mem_addr,
   input wire logic [scc_pkg::WORD_W-1:0] mem_word,
   // Programming mode status
   output logic program_selected
);

   // Synchronised pins, system domain
   logic sel_low_s, oe_s, page_s, ser_s, pick_s, data_s;
   logic [1:0] choice_s;
   // Flags back from the serial domain
   logic done_s, ack_s;
   // Power-up sequencing
   logic pwr_busy;

   // System-domain state
   logic clr_req_ff, nxt_clr_req;
   logic cnt_en_ff, nxt_cnt_en;
   logic page_eff_ff, nxt_page_eff;
   logic [1:0] choice_ff, nxt_choice;
   logic data_oe_n_ff, nxt_data_oe_n;
   logic ready_oe_n_ff, nxt_ready_oe_n;
   logic ready_out_ff;
   logic prog_sel_ff, nxt_prog_sel;
   logic chain_low_ff, nxt_chain_low;
   scc_pkg::scc_chain_e chain_st_ff, nxt_chain_st;
   logic read_mode; // Configuration readout, not programming

   // Serial-domain state
   logic lk_rst, lk_en, lk_clr, lk_page;
   logic [1:0] lk_choice;
   logic [scc_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
   logic [scc_pkg::BIT_W-1:0] bit_ff, nxt_bit;
   logic done_ff, nxt_done;
   logic ack_ff, nxt_ack;
   logic dout_ff, nxt_dout;
   logic [scc_pkg::ADDR_W-1:0] lk_base, lk_last;

   // Pins into the system domain
   scc_sync #(.W(8)) u_pin_sync (
      .clk(sys_clk),
      .rst(reset),
      .d({select_low, reset_oe, page_mode_on, partition_choice, program_path_on,
          program_device_pick, data_in}),
      .q({sel_low_s, oe_s, page_s, choice_s, ser_s, pick_s, data_s})
   );

   // Serial-domain flags into the system domain
   scc_sync #(.W(2)) u_back_sync (
      .clk(sys_clk),
      .rst(reset),
      .d({done_ff, ack_ff}),
      .q({done_s, ack_s})
   );

   // Control levels into the serial domain; no reset, clock may be idle
   scc_sync #(.W(6)) u_link_sync (
      .clk(serial_config_clock),
      .rst(1'b0),
      .d({pwr_busy, cnt_en_ff, clr_req_ff, page_eff_ff, choice_ff}),
      .q({lk_rst, lk_en, lk_clr, lk_page, lk_choice})
   );

   // Power-up hold
   scc_powerup #(.CYC(PWRUP_CYC)) u_pwrup (
      .sys_clk(sys_clk),
      .reset(reset),
      .busy_ff(pwr_busy)
   );

   assign read_mode = ser_s;

   // System-domain control: clear handshake, enables, pin drives
   always_comb
   begin
      // Clear request stays up until the serial side has acknowledged
      if (!oe_s || pwr_busy)
         nxt_clr_req = 1'b1;
      else if (ack_s)
         nxt_clr_req = 1'b0;
      else
         nxt_clr_req = clr_req_ff;
      // Counting only with select low, enable high, not yet finished
      nxt_cnt_en = read_mode && !sel_low_s && oe_s && !clr_req_ff && !ack_s &&
                   !done_s && !pwr_busy;
      // Drive data only while reading; float once the last bit is out
      nxt_data_oe_n = !(read_mode && !sel_low_s && oe_s && !done_s &&
                        !clr_req_ff && !pwr_busy);
      // Paging inputs count only in readout mode
      nxt_page_eff = read_mode && page_s;
      nxt_choice = read_mode ? choice_s : 2'h0;
      // Ready pulled low until the power-up sequence ends
      nxt_ready_oe_n = !pwr_busy;
      // Device pick is the chip select in programming mode
      nxt_prog_sel = !ser_s && pick_s;
   end

   // System-domain registers
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         clr_req_ff <= 1'b1;
         cnt_en_ff <= 1'b0;
         data_oe_n_ff <= 1'b1;
         page_eff_ff <= 1'b0;
         choice_ff <= 2'h0;
         ready_oe_n_ff <= 1'b0;
         ready_out_ff <= 1'b0;
         prog_sel_ff <= 1'b0;
      end
      else
      begin
         clr_req_ff <= nxt_clr_req;
         cnt_en_ff <= nxt_cnt_en;
         data_oe_n_ff <= nxt_data_oe_n;
         page_eff_ff <= nxt_page_eff;
         choice_ff <= nxt_choice;
         ready_oe_n_ff <= nxt_ready_oe_n;
         ready_out_ff <= 1'b0;
         prog_sel_ff <= nxt_prog_sel;
      end
   end

   // Cascade output sequencing
   always_comb
   begin
      nxt_chain_st = chain_st_ff;
      nxt_chain_low = 1'b1;
      case (chain_st_ff)
         scc_pkg::CH_IDLE:
         begin
            // Last bit out with the device still selected
            if (read_mode && done_s && !sel_low_s && oe_s)
            begin
               nxt_chain_st = scc_pkg::CH_LOW;
               nxt_chain_low = 1'b0;
            end
         end
         scc_pkg::CH_LOW:
         begin
            nxt_chain_low = 1'b0;
            if (!oe_s || !read_mode)
            begin
               nxt_chain_st = scc_pkg::CH_IDLE;
               nxt_chain_low = 1'b1;
            end
            else if (sel_low_s)
            begin
               nxt_chain_st = scc_pkg::CH_FOLLOW;
               nxt_chain_low = 1'b1;
            end
         end
         scc_pkg::CH_FOLLOW:
         begin
            // Mirrors select until enable drops, then high until re-read
            nxt_chain_low = sel_low_s;
            if (!oe_s || !read_mode)
            begin
               nxt_chain_st = scc_pkg::CH_IDLE;
               nxt_chain_low = 1'b1;
            end
         end
         default:
         begin
            nxt_chain_st = scc_pkg::CH_IDLE;
         end
      endcase
   end

   // Cascade registers
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         chain_st_ff <= scc_pkg::CH_IDLE;
         chain_low_ff <= 1'b1;
      end
      else
      begin
         chain_st_ff <= nxt_chain_st;
         chain_low_ff <= nxt_chain_low;
      end
   end

   // Active range; only a clear loads the base, but the last address follows page changes mid-read
   assign lk_base = scc_pkg::part_base(BIG_PART, lk_page, lk_choice);
   assign lk_last = scc_pkg::part_last(BIG_PART, lk_page, lk_choice);

   // Serial domain: counters, data bit, completion
   always_comb
   begin
      nxt_addr = addr_ff;
      nxt_bit = bit_ff;
      nxt_done = done_ff;
      nxt_dout = dout_ff;
      nxt_ack = 1'b0;
      if (lk_rst || lk_clr)
      begin
         // Back to the start of the active range
         nxt_addr = lk_base;
         nxt_bit = scc_pkg::BIT_RST;
         nxt_done = 1'b0;
         nxt_ack = lk_clr && !lk_rst;
      end
      else if (lk_en && !done_ff)
      begin
         // One bit per rising edge, then advance
         nxt_dout = mem_word[bit_ff];
         if (bit_ff == scc_pkg::BIT_LAST)
         begin
            nxt_bit = scc_pkg::BIT_RST;
            if (addr_ff == lk_last)
               nxt_done = 1'b1;
            else
               nxt_addr = addr_ff + 19'h00001;
         end
         else
         begin
            nxt_bit = bit_ff + 4'h1;
         end
      end
   end

   // Serial-domain registers; reset arrives as a synchronised level
   always_ff @(posedge serial_config_clock)
   begin
      addr_ff <= nxt_addr;
      bit_ff <= nxt_bit;
      done_ff <= nxt_done;
      ack_ff <= nxt_ack;
      dout_ff <= nxt_dout;
   end

   // Outputs straight from flops
   assign data_out = dout_ff;
   assign data_oe_n = data_oe_n_ff;
   assign chain_out_low = chain_low_ff;
   assign ready_out = ready_out_ff;
   assign ready_oe_n = ready_oe_n_ff;
   assign mem_addr = addr_ff;
   assign program_selected = prog_sel_ff;

   // Checks, system domain; the select pin is low when the device is selected
   a_float_oe_low: assert property (@(posedge sys_clk) disable iff (reset)
      !oe_s |=> data_oe_n_ff && clr_req_ff) else $error("data driven while enable low");
   a_float_deselect: assert property (@(posedge sys_clk) disable iff (reset)
      sel_low_s |=> data_oe_n_ff && !cnt_en_ff) else $error("drive or count while deselected");
   a_float_after_last: assert property (@(posedge sys_clk) disable iff (reset)
      done_s |=> data_oe_n_ff) else $error("data driven after last bit");
   a_drive_gated: assert property (@(posedge sys_clk) disable iff (reset)
      !data_oe_n_ff |-> $past(!sel_low_s && oe_s && read_mode))
      else $error("data driven without select and enable");
   a_chain_asserts: assert property (@(posedge sys_clk) disable iff (reset)
      (chain_st_ff == scc_pkg::CH_IDLE && read_mode && done_s && !sel_low_s && oe_s)
      |=> !chain_out_low && chain_st_ff == scc_pkg::CH_LOW)
      else $error("cascade output missed the end of data");
   a_chain_holds: assert property (@(posedge sys_clk) disable iff (reset)
      (chain_st_ff == scc_pkg::CH_LOW && !sel_low_s && oe_s && read_mode) |=> !chain_out_low)
      else $error("cascade output released too early");
   a_chain_follows: assert property (@(posedge sys_clk) disable iff (reset)
      (chain_st_ff == scc_pkg::CH_FOLLOW && oe_s && read_mode)
      |=> chain_out_low == $past(sel_low_s)) else $error("cascade not following select");
   a_chain_released: assert property (@(posedge sys_clk) disable iff (reset)
      (!oe_s && !done_s) |=> chain_out_low) else $error("cascade low after enable fell");
   a_ready_powerup: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(pwr_busy) |-> !ready_oe_n ##1 ready_oe_n) else $error("ready not released");
   a_prog_pick: assert property (@(posedge sys_clk) disable iff (reset)
      !ser_s |=> program_selected == $past(pick_s) && !page_eff_ff)
      else $error("program select or paging wrong in program mode");
   // Checks, serial domain
   a_link_clear: assert property (@(posedge serial_config_clock) disable iff (lk_rst)
      lk_clr |=> bit_ff == scc_pkg::BIT_RST && !done_ff && addr_ff == $past(lk_base))
      else $error("counter not cleared");
   a_link_step: assert property (@(posedge serial_config_clock) disable iff (lk_rst)
      (lk_en && !lk_clr && !done_ff && bit_ff != scc_pkg::BIT_LAST)
      |=> bit_ff == $past(bit_ff) + 4'h1) else $error("bit counter did not advance");
   a_link_range: assert property (@(posedge serial_config_clock) disable iff (lk_rst)
      (!lk_clr && $stable(lk_last)) |-> addr_ff <= lk_last)
      else $error("address beyond active range");

endmodule

// *** scc_readout_tb.sv ***
/*
 * Self-checking bench for the readout block: power-up, paging bases,
 * bit order, select and enable gating, and the programming mode.
 * Assumes a full readout is too long to run, so cascade assertion at
 * the range top is left to the design's own assertions.
 */
`timescale 1ns/1ps
module scc_readout_tb;
   // Short power-up hold keeps the run brief
   localparam int PWR = 4;
   // Pins and array port
   logic sys_clk, reset, ser_clk, select_low, reset_oe, page_mode_on;
   logic program_path_on, program_device_pick, data_out, data_oe_n;
   logic chain_out_low, ready_out, ready_oe_n, program_selected, run;
   logic [1:0] partition_choice;
   logic [18:0] mem_addr, prev_addr, first_addr;
   logic [15:0] mem_word, cap;
   wire logic data_wire;
   wire logic next_sel_low;
   // Bench bookkeeping
   int miscompares = 0;
   int checked = 0;
   int words = 0;
   logic watch = 1'b0;

   // Pull-up makes a floated pin read high
   assign data_wire = data_oe_n ? 1'b1 : data_out;

   // A downstream device's select hangs on the cascade output
   assign next_sel_low = chain_out_low;

   // Array contents differ per partition so a wrong base shows
   function automatic logic [15:0] word_of(input logic [18:0] a);
      return a[15:0] ^ {a[18:16], 13'h0B5A};
   endfunction
   assign mem_word = word_of(mem_addr);

   scc_readout #(.BIG_PART(1'b0), .PWRUP_CYC(PWR)) DUT (
      .sys_clk(sys_clk), .reset(reset), .serial_config_clock(ser_clk),
      .select_low(select_low), .reset_oe(reset_oe), .page_mode_on(page_mode_on),
      .partition_choice(partition_choice), .program_path_on(program_path_on),
      .program_device_pick(program_device_pick), .data_in(data_wire),
      .data_out(data_out), .data_oe_n(data_oe_n), .chain_out_low(chain_out_low),
      .ready_out(ready_out), .ready_oe_n(ready_oe_n), .mem_addr(mem_addr),
      .mem_word(mem_word), .program_selected(program_selected));

   scc_fpga_model master (.run(run), .data_wire(data_wire),
      .serial_config_clock(ser_clk), .cap(cap));

   // System clock, 4 ns period
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic summarize();
      if (miscompares == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic sys_wait(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   // One burst of serial edges, ending on a falling system edge
   task automatic edges(input int n);
      run = 1'b1;
      repeat (n) @(posedge ser_clk);
      run = 1'b0;
      #10;
      @(negedge sys_clk);
   endtask

   // Each word is judged when the address steps past it
   always @(posedge ser_clk)
   begin
      #1;
      if (watch && mem_addr !== prev_addr)
      begin
         if (words == 0)
            first_addr = prev_addr;
         words++;
         chk("word", 32'(word_of(prev_addr)), 32'(cap));
         chk("next_addr", 32'(prev_addr + 19'h00001), 32'(mem_addr));
      end
      prev_addr = mem_addr;
   end

   // Reset pulse on the enable pin with the chosen paging inputs
   task automatic clear(input logic pg, input logic [1:0] sel, input logic [18:0] base);
      page_mode_on = pg;
      partition_choice = sel;
      reset_oe = 1'b0;
      sys_wait(6);
      chk("float_on_clear", 32'h1, 32'(data_oe_n));
      edges(6);
      chk("clear_base", 32'(base), 32'(mem_addr));
   endtask

   task automatic t_powerup();
      chk("ready_low_in_reset", 32'h0, 32'(ready_oe_n));
      reset = 1'b0;
      sys_wait(2);
      chk("ready_low_after", 32'h0, 32'(ready_oe_n));
      chk("ready_level", 32'h0, 32'(ready_out));
      for (int i = 0; i < PWR + 20 && ready_oe_n !== 1'b1; i++)
         @(negedge sys_clk);
      chk("ready_released", 32'h1, 32'(ready_oe_n));
      edges(6);
      chk("powerup_addr", 32'h0, 32'(mem_addr));
      chk("powerup_float", 32'h1, 32'(data_oe_n));
   endtask

   // Three whole words from the chosen range, bits LSB first
   task automatic t_read(input logic pg, input logic [1:0] sel, input logic [18:0] base);
      select_low = 1'b0;
      clear(pg, sel, base);
      reset_oe = 1'b1;
      sys_wait(6);
      words = 0;
      watch = 1'b1;
      edges(58);
      watch = 1'b0;
      chk("words", 32'h3, 32'(words));
      chk("first_addr", 32'(base), 32'(first_addr));
      chk("driving", 32'h0, 32'(data_oe_n));
      chk("chain_idle", 32'h1, 32'(chain_out_low));
      chk("next_deselected", 32'h1, 32'(next_sel_low));
   endtask

   task automatic t_pages();
      t_read(1'b0, 2'h3, 19'h00000);
      for (int s = 0; s < 4; s++)
         t_read(1'b1, 2'(s), 19'(s) << 16);
   endtask

   task automatic t_select();
      logic [18:0] a;
      select_low = 1'b1;
      clear(1'b0, 2'h0, 19'h00000);
      reset_oe = 1'b1;
      sys_wait(8);
      edges(40);
      chk("frozen_addr", 32'h0, 32'(mem_addr));
      chk("frozen_float", 32'h1, 32'(data_oe_n));
      select_low = 1'b0;
      sys_wait(8);
      edges(40);
      chk("resume_drive", 32'h0, 32'(data_oe_n));
      chk("resume_count", 32'h1, 32'(mem_addr > 19'h00000));
      a = mem_addr;
      select_low = 1'b1;
      sys_wait(8);
      chk("standby_float", 32'h1, 32'(data_oe_n));
      edges(40);
      chk("standby_addr", 32'(a), 32'(mem_addr));
      reset_oe = 1'b0;
      sys_wait(8);
      edges(6);
      chk("clear_deselected", 32'h0, 32'(mem_addr));
      chk("clear_float", 32'h1, 32'(data_oe_n));
      select_low = 1'b0;
   endtask

   task automatic t_program();
      logic [18:0] a;
      a = mem_addr;
      program_path_on = 1'b0;
      program_device_pick = 1'b1;
      reset_oe = 1'b1;
      page_mode_on = 1'b1;
      sys_wait(8);
      edges(40);
      chk("prog_float", 32'h1, 32'(data_oe_n));
      chk("prog_addr", 32'(a), 32'(mem_addr));
      chk("prog_pick_on", 32'h1, 32'(program_selected));
      program_device_pick = 1'b0;
      sys_wait(8);
      chk("prog_pick_off", 32'h0, 32'(program_selected));
      program_path_on = 1'b1;
      sys_wait(8);
   endtask

   // Watchdog: far beyond the eight or so microseconds the run needs
   initial
   begin
      #200000;
      miscompares++;
      summarize();
   end

   // Main sequence
   initial
   begin
      reset = 1'b1;
      run = 1'b0;
      select_low = 1'b1;
      reset_oe = 1'b1;
      page_mode_on = 1'b0;
      partition_choice = 2'h0;
      program_path_on = 1'b1;
      program_device_pick = 1'b0;
      prev_addr = 19'h00000;
      first_addr = 19'h00000;
      repeat (4) @(negedge sys_clk);
      t_powerup();
      t_pages();
      t_select();
      t_program();
      summarize();
   end
endmodule

// *** scc_sync.sv ***
/*
 * Two-stage level synchroniser, any width.
 * Assumes each bit is a slow level; multi-bit groups may skew by one cycle.
 */
`timescale 1ns/1ps
module scc_sync #(
   parameter int W = 1
) (
   // Destination clock and reset
   input wire logic clk,
   input wire logic rst,
   // Level in and out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_ff; // First stage, read only by the second
   logic [W-1:0] nxt_meta;
   logic [W-1:0] nxt_q;

   // Next values
   always_comb
   begin
      nxt_meta = rst ? '0 : d;
      nxt_q = rst ? '0 : meta_ff;
   end

   // Both stages
   always_ff @(posedge clk)
   begin
      meta_ff <= nxt_meta;
      q <= nxt_q;
   end

endmodule
